// ### pcp_regs.vh
`ifndef PCP_REGS_VH
`define PCP_REGS_VH

// Register byte offsets
`define PCP_OFF_TB_SETUP_A   8'h00
`define PCP_OFF_TB_SETUP_B   8'h04
`define PCP_OFF_PULSE_A      8'h08
`define PCP_OFF_PULSE_B      8'h0C
`define PCP_OFF_DEAD_TIME    8'h10
`define PCP_OFF_OVR_SELECT   8'h14
`define PCP_OFF_OVR_STATE    8'h18
`define PCP_OFF_TB_COUNT     8'h20
`define PCP_OFF_PERIOD       8'h24
`define PCP_OFF_EVT_COMPARE  8'h28
`define PCP_OFF_DUTY0        8'h2C
`define PCP_OFF_DUTY1        8'h30
`define PCP_OFF_DUTY2        8'h34
`define PCP_OFF_DUTY3        8'h38
`define PCP_OFF_INT_STATUS   8'h3C
`define PCP_OFF_INT_MASK     8'h40

// Field positions
`define PCP_TBA_POST_HI      7
`define PCP_TBA_POST_LO      4
`define PCP_TBA_PRE_HI       3
`define PCP_TBA_PRE_LO       2
`define PCP_TBA_MODE_HI      1
`define PCP_TBA_MODE_LO      0
`define PCP_TBB_RUN          7
`define PCP_TBB_DIR          6
`define PCP_PA_PINEN_HI      6
`define PCP_PA_PINEN_LO      4
`define PCP_PB_SEVPOST_HI    7
`define PCP_PB_SEVPOST_LO    4
`define PCP_PB_SEVDIR        3
`define PCP_PB_UDIS          1
`define PCP_PB_OSYNC         0
`define PCP_INT_TB           0
`define PCP_INT_SEV          1

// Time base modes
`define PCP_MODE_FREE        2'b00
`define PCP_MODE_SINGLE      2'b01
`define PCP_MODE_UPDN        2'b10
`define PCP_MODE_UPDN_DBL    2'b11

// Prescaler terminal counts in aclk cycles (4, 16, 64, 256)
`define PCP_PRE_LAST_1       8'h03
`define PCP_PRE_LAST_4       8'h0F
`define PCP_PRE_LAST_16      8'h3F
`define PCP_PRE_LAST_64      8'hFF

// Reset values
`define PCP_RST_PULSE_A      7'h70
`define PCP_RST_OVR_SELECT   8'hFF
`define PCP_RST_ZERO8        8'h00

// Bus responses
`define PCP_RESP_OKAY        2'b00
`define PCP_RESP_SLVERR      2'b10

`endif

// ### pcp_deadtime.v
`timescale 1ns/1ps
`include "pcp_regs.vh"

module pcp_deadtime (
	input  wire       aclk,
	input  wire       aresetn,
	input  wire       gen,
	input  wire       compl,
	input  wire [7:0] dead,
	output reg        out_odd,
	output reg        out_even
);

	reg       prev_q;
	reg [7:0] cnt_q;

	always @(posedge aclk) begin
		if (!aresetn) begin
			prev_q   <= 1'b0;
			cnt_q    <= `PCP_RST_ZERO8;
			out_odd  <= 1'b0;
			out_even <= 1'b0;
		end else if (!compl) begin
			// Independent pair: both pins follow the generator
			prev_q   <= gen;
			cnt_q    <= `PCP_RST_ZERO8;
			out_odd  <= gen;
			out_even <= gen;
		end else if (gen != prev_q) begin
			// Both pins off for the dead interval
			prev_q <= gen;
			if (dead == `PCP_RST_ZERO8) begin
				out_odd  <= gen;
				out_even <= ~gen;
			end else begin
				cnt_q    <= dead - 8'h01;
				out_odd  <= 1'b0;
				out_even <= 1'b0;
			end
		end else if (cnt_q != `PCP_RST_ZERO8) begin
			cnt_q <= cnt_q - 8'h01;
		end else begin
			// Even pin is the inverse of the odd pin
			out_odd  <= prev_q;
			out_even <= ~prev_q;
		end
	end

endmodule // pcp_deadtime

// ### pcp_core.v
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "pcp_regs.vh"

// Operation
// - Four duty generators drive eight pins
// - Pair n uses pins 2n and 2n+1
// - Complementary pair: even pin inverts odd pin
// - Programmable dead time between pair switching
// - 12-bit time base with prescaler, postscaler
// - Value registers are double-buffered
// - Duty resolution up to 14 bits
// - Edge, center aligned and single pulse
// - Double-update interrupts for asymmetric center updates
// - Software override of individual pin states
// - Special event compare triggers other peripherals
// - Debug mode forces outputs inactive
// - Reduced build: three generators, six pins
// - Pair mode bit: set independent, clear complementary
// - Mode field selects free, single, up/down
// - Stopping keeps time base count value
module pcp_core #(
	parameter PAIRS = 4
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        debug_mode,
	output reg  [7:0]  pwm_out,
	output reg  [7:0]  pwm_oe,
	output reg         event_trigger,
	output reg         irq
);

	reg  [7:0]  tba_q;
	reg         run_q;
	reg  [6:0]  pca_q;
	reg  [7:0]  pcb_q;
	reg  [7:0]  dead_q;
	reg  [7:0]  ovs_q;
	reg  [7:0]  ovt_q;
	reg  [7:0]  ovs_act_q;
	reg  [7:0]  ovt_act_q;
	reg  [11:0] per_buf_q;
	reg  [11:0] per_act_q;
	reg  [11:0] sev_buf_q;
	reg  [11:0] sev_act_q;
	reg  [13:0] duty_buf_q [0:3];
	reg  [13:0] duty_act_q [0:3];
	reg  [11:0] tb_q;
	reg         dir_q;
	reg  [7:0]  pre_q;
	reg  [3:0]  post_q;
	reg  [3:0]  sevpost_q;
	reg  [1:0]  sts_q;
	reg  [1:0]  msk_q;
	reg         dbg_s1_q;
	reg         dbg_s2_q;
	reg  [7:0]  aw_addr_q;
	reg         aw_full_q;
	reg  [31:0] w_data_q;
	reg  [3:0]  w_strb_q;
	reg         w_full_q;
	reg  [7:0]  pin_en_d;
	reg  [7:0]  pre_last;
	wire [1:0]  mode      = tba_q[`PCP_TBA_MODE_HI:`PCP_TBA_MODE_LO];
	wire [1:0]  pre_sel   = tba_q[`PCP_TBA_PRE_HI:`PCP_TBA_PRE_LO];
	wire [3:0]  post_sel  = tba_q[`PCP_TBA_POST_HI:`PCP_TBA_POST_LO];
	wire [3:0]  sevp_sel  = pcb_q[`PCP_PB_SEVPOST_HI:`PCP_PB_SEVPOST_LO];
	wire [2:0]  pin_sel   = pca_q[`PCP_PA_PINEN_HI:`PCP_PA_PINEN_LO];
	wire [3:0]  pair_mode_sel = pca_q[3:0];
	wire        updn      = mode[1];
	wire        tick      = run_q & (pre_q == pre_last);
	wire        per_match = tick & (tb_q >= per_act_q) & ~(updn & dir_q);
	wire        zero_match = tick & updn & dir_q & (tb_q == 12'h000);
	wire        boundary  = (mode == `PCP_MODE_UPDN) ? zero_match :
		(mode == `PCP_MODE_UPDN_DBL) ? (per_match | zero_match) :
		per_match;
	wire        load_ok   = boundary & ~pcb_q[`PCP_PB_UDIS];
	wire        sev_hit   = tick & (tb_q == sev_act_q) &
		(dir_q == pcb_q[`PCP_PB_SEVDIR]);
	wire [1:0]  fine      = (pre_sel == 2'b00) ? pre_q[1:0] : 2'b00;
	wire [13:0] pos       = {tb_q, (dir_q ? ~fine : fine)};
	wire        do_write  = aw_full_q & w_full_q & ~s_axi_bvalid;
	wire [31:0] wmask     = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
		{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
	wire [31:0] wr_old;
	wire [31:0] wr_new    = (wr_old & ~wmask) | (w_data_q & wmask);
	wire        wr_hit;
	wire [31:0] rd_val;
	wire        rd_hit;
	wire        tb_load   = do_write & (aw_addr_q == `PCP_OFF_TB_COUNT);
	wire [7:0]  pin_drive;
	wire [7:0]  pin_mix   = (ovs_act_q & pin_drive) | (~ovs_act_q & ovt_act_q);
	reg         tb_evt;
	reg         sev_evt;

	function [32:0] regmux;
		input [7:0] a;
		begin
			regmux = {1'b1, 32'h00000000};
			case (a)
			`PCP_OFF_TB_SETUP_A:  regmux[7:0] = tba_q;
			`PCP_OFF_TB_SETUP_B:  regmux[7:6] = {run_q, dir_q};
			`PCP_OFF_PULSE_A:     regmux[6:0] = pca_q;
			`PCP_OFF_PULSE_B:     regmux[7:0] = pcb_q;
			`PCP_OFF_DEAD_TIME:   regmux[7:0] = dead_q;
			`PCP_OFF_OVR_SELECT:  regmux[7:0] = ovs_q;
			`PCP_OFF_OVR_STATE:   regmux[7:0] = ovt_q;
			`PCP_OFF_TB_COUNT:    regmux[11:0] = tb_q;
			`PCP_OFF_PERIOD:      regmux[11:0] = per_buf_q;
			`PCP_OFF_EVT_COMPARE: regmux[11:0] = sev_buf_q;
			`PCP_OFF_DUTY0:       regmux[13:0] = duty_buf_q[0];
			`PCP_OFF_DUTY1:       regmux[13:0] = duty_buf_q[1];
			`PCP_OFF_DUTY2:       regmux[13:0] = duty_buf_q[2];
			`PCP_OFF_DUTY3:       regmux[13:0] = duty_buf_q[3];
			`PCP_OFF_INT_STATUS:  regmux[1:0] = sts_q;
			`PCP_OFF_INT_MASK:    regmux[1:0] = msk_q;
			default:              regmux[32] = 1'b0;
			endcase
		end
	endfunction

	assign {wr_hit, wr_old} = regmux(aw_addr_q);
	assign {rd_hit, rd_val} = regmux(s_axi_araddr);

	always @* begin
		case (pre_sel)
		2'b00:   pre_last = `PCP_PRE_LAST_1;
		2'b01:   pre_last = `PCP_PRE_LAST_4;
		2'b10:   pre_last = `PCP_PRE_LAST_16;
		default: pre_last = `PCP_PRE_LAST_64;
		endcase
		case (pin_sel)
		3'b001:  pin_en_d = 8'h02;
		3'b010:  pin_en_d = 8'h03;
		3'b011:  pin_en_d = 8'h0F;
		3'b100:  pin_en_d = 8'h3F;
		3'b101:  pin_en_d = 8'hFF;
		3'b110:  pin_en_d = 8'h0A;
		3'b111:  pin_en_d = 8'hAA;
		default: pin_en_d = 8'h00;
		endcase
		tb_evt  = boundary & (post_q == post_sel);
		sev_evt = sev_hit & (sevpost_q == sevp_sel);
	end

	// Bus slave and register file
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `PCP_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= `PCP_RESP_OKAY;
			s_axi_rdata   <= 32'h00000000;
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			aw_addr_q <= `PCP_RST_ZERO8;
			w_data_q  <= 32'h00000000;
			w_strb_q  <= 4'h0;
			tba_q  <= `PCP_RST_ZERO8;
			run_q  <= 1'b0;
			pca_q  <= `PCP_RST_PULSE_A;
			pcb_q  <= `PCP_RST_ZERO8;
			dead_q <= `PCP_RST_ZERO8;
			ovs_q  <= `PCP_RST_OVR_SELECT;
			ovt_q  <= `PCP_RST_ZERO8;
			per_buf_q <= 12'h000;
			sev_buf_q <= 12'h000;
			duty_buf_q[0] <= 14'h0000;
			duty_buf_q[1] <= 14'h0000;
			duty_buf_q[2] <= 14'h0000;
			duty_buf_q[3] <= 14'h0000;
			sts_q <= 2'b00;
			msk_q <= 2'b00;
		end else begin
			s_axi_awready <= ~aw_full_q & ~s_axi_bvalid &
				~(s_axi_awvalid & s_axi_awready);
			s_axi_wready  <= ~w_full_q & ~s_axi_bvalid &
				~(s_axi_wvalid & s_axi_wready);
			if (s_axi_awvalid & s_axi_awready) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (s_axi_bvalid & s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (mode == `PCP_MODE_SINGLE && per_match)
				run_q <= 1'b0;
			// Hardware set wins over a same-cycle clear
			sts_q <= sts_q & ~((do_write && w_strb_q[0] &&
				aw_addr_q == `PCP_OFF_INT_STATUS) ?
				w_data_q[1:0] : 2'b00);
			if (do_write) begin
				aw_full_q    <= 1'b0;
				w_full_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? `PCP_RESP_OKAY :
					`PCP_RESP_SLVERR;
				case (aw_addr_q)
				`PCP_OFF_TB_SETUP_A:  tba_q <= wr_new[7:0];
				`PCP_OFF_TB_SETUP_B:  run_q <= wr_new[`PCP_TBB_RUN];
				`PCP_OFF_PULSE_A:     pca_q <= wr_new[6:0];
				`PCP_OFF_PULSE_B:     pcb_q <= wr_new[7:0] & 8'hFB;
				`PCP_OFF_DEAD_TIME:   dead_q <= wr_new[7:0];
				`PCP_OFF_OVR_SELECT:  ovs_q <= wr_new[7:0];
				`PCP_OFF_OVR_STATE:   ovt_q <= wr_new[7:0];
				`PCP_OFF_PERIOD:      per_buf_q <= wr_new[11:0];
				`PCP_OFF_EVT_COMPARE: sev_buf_q <= wr_new[11:0];
				`PCP_OFF_DUTY0:       duty_buf_q[0] <= wr_new[13:0];
				`PCP_OFF_DUTY1:       duty_buf_q[1] <= wr_new[13:0];
				`PCP_OFF_DUTY2:       duty_buf_q[2] <= wr_new[13:0];
				`PCP_OFF_DUTY3:       duty_buf_q[3] <= wr_new[13:0];
				`PCP_OFF_INT_MASK:    msk_q <= wr_new[1:0];
				default: ;
				endcase
			end
			if (tb_evt)
				sts_q[`PCP_INT_TB] <= 1'b1;
			if (sev_evt)
				sts_q[`PCP_INT_SEV] <= 1'b1;
			s_axi_arready <= ~s_axi_rvalid &
				~(s_axi_arvalid & s_axi_arready);
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_val;
				s_axi_rresp  <= rd_hit ? `PCP_RESP_OKAY :
					`PCP_RESP_SLVERR;
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Time base, buffers and postscalers
	always @(posedge aclk) begin
		if (!aresetn) begin
			tb_q      <= 12'h000;
			dir_q     <= 1'b0;
			pre_q     <= `PCP_RST_ZERO8;
			post_q    <= 4'h0;
			sevpost_q <= 4'h0;
			per_act_q <= 12'h000;
			sev_act_q <= 12'h000;
			ovs_act_q <= `PCP_RST_OVR_SELECT;
			ovt_act_q <= `PCP_RST_ZERO8;
			duty_act_q[0] <= 14'h0000;
			duty_act_q[1] <= 14'h0000;
			duty_act_q[2] <= 14'h0000;
			duty_act_q[3] <= 14'h0000;
		end else begin
			pre_q <= (tick | ~run_q) ? `PCP_RST_ZERO8 : pre_q + 8'h01;
			if (tb_load) begin
				tb_q  <= wr_new[11:0];
				dir_q <= 1'b0;
			end else if (tick) begin
				if (!updn) begin
					tb_q <= per_match ? 12'h000 : tb_q + 12'h001;
				end else if (!dir_q) begin
					if (per_match) begin
						dir_q <= 1'b1;
						tb_q  <= (tb_q == 12'h000) ? tb_q :
							tb_q - 12'h001;
					end else begin
						tb_q <= tb_q + 12'h001;
					end
				end else if (zero_match) begin
					dir_q <= 1'b0;
					tb_q  <= (per_act_q == 12'h000) ? tb_q :
						tb_q + 12'h001;
				end else begin
					tb_q <= tb_q - 12'h001;
				end
			end
			// A stopped time base holds its count
			if (boundary)
				post_q <= tb_evt ? 4'h0 : post_q + 4'h1;
			if (sev_hit)
				sevpost_q <= sev_evt ? 4'h0 : sevpost_q + 4'h1;
			if (load_ok) begin
				per_act_q     <= per_buf_q;
				duty_act_q[0] <= duty_buf_q[0];
				duty_act_q[1] <= duty_buf_q[1];
				duty_act_q[2] <= duty_buf_q[2];
				duty_act_q[3] <= duty_buf_q[3];
			end
			if (boundary)
				sev_act_q <= sev_buf_q;
			if (!pcb_q[`PCP_PB_OSYNC] || boundary || !run_q) begin
				ovs_act_q <= ovs_q;
				ovt_act_q <= ovt_q;
			end
		end
	end

	genvar n;
	generate
		for (n = 0; n < 4; n = n + 1) begin : g_pair
			wire gen = run_q & (duty_act_q[n] > pos);
			if (n < PAIRS) begin : g_on
				pcp_deadtime u_dt (
					.aclk     (aclk),
					.aresetn  (aresetn),
					.gen      (gen),
					.compl    (~pair_mode_sel[n]),
					.dead     (dead_q),
					.out_odd  (pin_drive[2*n+1]),
					.out_even (pin_drive[2*n])
				);
			end else begin : g_off
				assign pin_drive[2*n+1] = 1'b0;
				assign pin_drive[2*n]   = 1'b0;
			end
		end
	endgenerate

	wire [7:0] pin_cfg = (PAIRS < 4) ? 8'h3F : 8'hFF;

	always @(posedge aclk) begin
		if (!aresetn) begin
			dbg_s1_q      <= 1'b0;
			dbg_s2_q      <= 1'b0;
			pwm_out       <= `PCP_RST_ZERO8;
			pwm_oe        <= `PCP_RST_ZERO8;
			event_trigger <= 1'b0;
			irq           <= 1'b0;
		end else begin
			dbg_s1_q <= debug_mode;
			dbg_s2_q <= dbg_s1_q;
			// Override mixes software state per pin
			pwm_out <= (dbg_s2_q ? `PCP_RST_ZERO8 : pin_mix) &
				pin_en_d & pin_cfg;
			pwm_oe  <= pin_en_d & pin_cfg;
			event_trigger <= sev_evt;
			irq <= |(sts_q & msk_q);
		end
	end

endmodule // pcp_core

// ### pcp_core_checker.sv
`timescale 1ns/1ps

module pcp_core_checker (
	input wire       aclk,
	input wire       aresetn,
	input wire       s_axi_awvalid,
	input wire       s_axi_awready,
	input wire       s_axi_wvalid,
	input wire       s_axi_wready,
	input wire       s_axi_bvalid,
	input wire       s_axi_bready,
	input wire       s_axi_arvalid,
	input wire       s_axi_arready,
	input wire       s_axi_rvalid,
	input wire       s_axi_rready,
	input wire       debug_mode,
	input wire [7:0] pwm_out,
	input wire [7:0] pwm_oe,
	input wire       event_trigger,
	input wire       irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	reg [7:0] oe1_q;
	reg [7:0] oe2_q;
	always @(posedge aclk) begin
		oe1_q <= pwm_oe;
		oe2_q <= oe1_q;
	end
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
		!irq && !event_trigger && pwm_out == 8'h00 && !s_axi_bvalid)
		else $error("outputs active after reset");
	a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write response missing");
	a_read_answer: assert property (rd_taken |-> ##[1:2] s_axi_rvalid)
		else $error("read data missing");
	a_b_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response held after handshake");
	a_r_clear: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data held after handshake");
	a_debug_quiet: assert property (debug_mode [*4] |-> pwm_out == 8'h00)
		else $error("pins active in debug");
	a_oe_mask: assert property (pwm_oe == oe1_q && oe1_q == oe2_q
		|-> (pwm_out & ~pwm_oe) == 8'h00) else $error("disabled pin driven");
	a_event_pulse: assert property (event_trigger |=> !event_trigger)
		else $error("event trigger wider than one cycle");
endmodule // pcp_core_checker

bind pcp_core pcp_core_checker chk_u (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.debug_mode(debug_mode), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
	.event_trigger(event_trigger), .irq(irq));

// ### pcp_bridge_model.sv
`timescale 1ns/1ps

module pcp_bridge_model (
	input  wire    aclk,
	input  wire    hi_on,
	input  wire    lo_on,
	output integer n_shoot,
	output integer gap_min
);
	integer gap;
	initial begin
		n_shoot = 0;
		gap_min = 999;
		gap = 0;
	end
	// Half-bridge legs: both on shorts the supply, both off is dead time
	always @(posedge aclk) begin
		if (hi_on && lo_on)
			n_shoot <= n_shoot + 1;
		if (!hi_on && !lo_on)
			gap <= gap + 1;
		else begin
			if (gap > 0 && gap < gap_min)
				gap_min <= gap;
			gap <= 0;
		end
	end
endmodule // pcp_bridge_model

// ### power_control_pwm_core_test.sv
`timescale 1ns/1ps

module power_control_pwm_core_test;
	reg        aclk = 1'b0, aresetn = 1'b0, debug_mode = 1'b0;
	reg        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	reg        arvalid = 1'b0, rready = 1'b0;
	reg [7:0]  awaddr = 8'h00, araddr = 8'h00, a;
	reg [31:0] wdata = 32'h0, rd, v;
	reg [3:0]  wstrb = 4'hF;
	reg [1:0]  rs;
	wire       awready, wready, bvalid, arready, rvalid, evt, irq;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [7:0] pwm_out, pwm_oe;
	integer    n_mismatch = 0, n_tests = 0, cyc = 0, n_shoot, gap_min, i, k;

	pcp_core #(.PAIRS(4)) dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .debug_mode(debug_mode), .pwm_out(pwm_out),
		.pwm_oe(pwm_oe), .event_trigger(evt), .irq(irq));
	pcp_bridge_model br_u (.aclk(aclk), .hi_on(pwm_out[1]),
		.lo_on(pwm_out[0]), .n_shoot(n_shoot), .gap_min(gap_min));

	always #5 aclk = ~aclk;

	task report_and_stop;
		begin
			if (n_mismatch == 0 && n_tests > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask

	always @(posedge aclk) begin
		cyc = cyc + 1;
		if (cyc == 40000) begin
			n_mismatch = n_mismatch + 1;
			report_and_stop;
		end
	end

	task check(input [31:0] seen, input [31:0] exp);
		begin
			n_tests = n_tests + 1;
			if (seen !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
			end
		end
	endtask

	function [7:0] oe_exp(input [2:0] e);
		case (e)
			3'h0: oe_exp = 8'h00;
			3'h1: oe_exp = 8'h02;
			3'h2: oe_exp = 8'h03;
			3'h3: oe_exp = 8'h0F;
			3'h4: oe_exp = 8'h3F;
			3'h5: oe_exp = 8'hFF;
			3'h6: oe_exp = 8'h0A;
			default: oe_exp = 8'hAA;
		endcase
	endfunction

	task wr(input [7:0] ad, input [31:0] d);
		reg aw, w;
		begin
			aw = 1'b0;
			w = 1'b0;
			@(posedge aclk);
			awaddr <= ad;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			while (!(aw && w)) begin
				@(posedge aclk);
				if (!aw && awready === 1'b1) begin
					aw = 1'b1;
					awvalid <= 1'b0;
				end
				if (!w && wready === 1'b1) begin
					w = 1'b1;
					wvalid <= 1'b0;
				end
			end
			while (bvalid !== 1'b1) @(posedge aclk);
			rs = bresp;
			bready <= 1'b0;
		end
	endtask

	task rdr(input [7:0] ad);
		begin
			@(posedge aclk);
			araddr <= ad;
			arvalid <= 1'b1;
			rready <= 1'b1;
			@(posedge aclk);
			while (arready !== 1'b1) @(posedge aclk);
			arvalid <= 1'b0;
			while (rvalid !== 1'b1) @(posedge aclk);
			rd = rdata;
			rs = rresp;
			rready <= 1'b0;
		end
	endtask

	initial begin
		v = $urandom(91202);
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rdr(8'h08);
		check(rd, 32'h70);
		rdr(8'h14);
		check(rd, 32'hFF);
		check({24'h0, pwm_oe}, 32'hAA);
		rdr(8'h1C);
		check({30'h0, rs}, 32'h2);
		check(rd, 32'h0);
		wr(8'h1C, 32'h5);
		check({30'h0, rs}, 32'h2);
		for (i = 0; i < 4; i = i + 1) begin
			a = 8'h2C + {i[5:0], 2'b00};
			v = $urandom & 32'hFFFF;
			wr(a, v);
			check({30'h0, rs}, 32'h0);
			rdr(a);
			check(rd, v & 32'h3FFF);
		end
		for (i = 0; i < 8; i = i + 1) begin
			wr(8'h08, {25'h0, i[2:0], 4'h0});
			repeat (3) @(posedge aclk);
			check({24'h0, pwm_oe}, {24'h0, oe_exp(i[2:0])});
		end
		wr(8'h24, 32'h40);
		wr(8'h2C, 32'h80);
		wr(8'h10, 32'h4);
		wr(8'h08, 32'h50);
		wr(8'h00, 32'h0);
		wr(8'h04, 32'h80);
		repeat (1200) @(posedge aclk);
		check(n_shoot, 0);
		check({31'h0, gap_min >= 4 && gap_min < 999}, 32'h1);
		wr(8'h08, 32'h51);
		repeat (20) @(posedge aclk);
		for (k = 0; k < 300; k = k + 1) begin
			@(posedge aclk);
			check({31'h0, pwm_out[0]}, {31'h0, pwm_out[1]});
		end
		debug_mode <= 1'b1;
		repeat (5) @(posedge aclk);
		check({24'h0, pwm_out}, 32'h0);
		debug_mode <= 1'b0;
		wr(8'h40, 32'h1);
		for (k = 0; k < 600 && irq !== 1'b1; k = k + 1) @(posedge aclk);
		check({31'h0, irq}, 32'h1);
		rdr(8'h3C);
		check({31'h0, rd[0]}, 32'h1);
		wr(8'h04, 32'h0);
		wr(8'h3C, 32'h1);
		rdr(8'h3C);
		check({31'h0, rd[0]}, 32'h0);
		wr(8'h04, 32'h80);
		wr(8'h40, 32'h0);
		repeat (3) @(posedge aclk);
		check({31'h0, irq}, 32'h0);
		wr(8'h28, 32'h10);
		for (k = 0; k < 600 && evt !== 1'b1; k = k + 1) @(posedge aclk);
		check({31'h0, evt}, 32'h1);
		for (i = 0; i < 4; i = i + 1) begin
			wr(8'h00, {30'h0, i[1:0]});
			rdr(8'h00);
			check(rd, {30'h0, i[1:0]});
		end
		wr(8'h04, 32'h0);
		rdr(8'h20);
		v = rd;
		repeat (40) @(posedge aclk);
		rdr(8'h20);
		check(rd, v);
		wr(8'h20, 32'h0);
		wr(8'h00, 32'h1);
		wr(8'h04, 32'h80);
		repeat (400) @(posedge aclk);
		rdr(8'h04);
		check(rd, 32'h0);
		wr(8'h14, 32'hFC);
		wr(8'h18, 32'h02);
		repeat (3) @(posedge aclk);
		check({24'h0, pwm_out}, 32'h56);
		report_and_stop;
	end
endmodule // power_control_pwm_core_test
